//--- lineif_pkg.sv
package lineif_pkg;
	// ****************************************
	// Serial frame layout
	// ****************************************
	localparam int ADDR_BITS = 7;
	localparam int DATA_BITS = 8;
	localparam int HEAD_BITS = 1 + ADDR_BITS;
	localparam int FRAME_BITS = HEAD_BITS + DATA_BITS;
	localparam logic [4:0] HEAD_LAST = 5'h07;
	localparam logic [4:0] FRAME_LAST = 5'h0F;
	localparam logic RW_READ = 1'b1;

	// ****************************************
	// Command register offsets
	// ****************************************
	localparam logic [6:0] CHAN_CTRL_ADDR = 7'h00;
	localparam logic [6:0] INT_MASK_ADDR = 7'h01;
	localparam logic [6:0] INT_STAT_ADDR = 7'h02;
	localparam logic [6:0] ALARM_STAT_ADDR = 7'h03;
	localparam logic [6:0] CLK_CTRL_ADDR = 7'h04;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_INT_EN = 0;
	localparam int CTRL_MUTE = 1;
	localparam int CTRL_ALL_ONES = 2;
	localparam int CTRL_NEAR_LOOP = 3;
	localparam int CTRL_FAR_LOOP = 4;
	localparam int CTRL_RX_ON = 5;
	localparam int CTRL_RX_MON = 6;
	localparam int CLK_RX_INV = 0;
	localparam int CLK_TX_INV = 1;
	localparam int EVT_LOS_SET = 0;
	localparam int EVT_LOS_CLR = 1;
	localparam int EVENT_COUNT = 2;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] CHAN_CTRL_RST = 8'h20;
	localparam logic [7:0] CLK_CTRL_RST = 8'h00;
	localparam logic [1:0] INT_MASK_RST = 2'h0;

	// ****************************************
	// Serial port states
	// ****************************************
	typedef enum logic [4:0] {
		SP_IDLE = 5'h01,
		SP_HEAD = 5'h02,
		SP_WDATA = 5'h04,
		SP_RDATA = 5'h08,
		SP_DONE = 5'h10
	} port_state_type;
endpackage

//--- pin_sync.sv
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinOut
);
	logic [WIDTH-1:0] firstReg;

	// ****************************************
	// Two flip-flops per pin
	// ****************************************
	generate
		for (genvar i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge sys_clk or negedge rstn) begin
				if (!rstn) begin
					firstReg[i] <= 1'b0;
					pinOut[i] <= 1'b0;
				end else begin
					firstReg[i] <= pinIn[i];
					pinOut[i] <= firstReg[i];
				end
			end
		end
	endgenerate
endmodule

//--- int_ctrl.sv
module int_ctrl #(
	parameter int EVENTS = 2
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic clearAll,
	input wire logic [EVENTS-1:0] events,
	input wire logic maskWe,
	input wire logic statusWe,
	input wire logic [EVENTS-1:0] wdata,
	input wire logic intEnable,
	output logic [EVENTS-1:0] statusReg,
	output logic [EVENTS-1:0] maskReg,
	output logic irqActive
);
	import lineif_pkg::*;
	logic [EVENTS-1:0] statusNext;
	logic [EVENTS-1:0] maskNext;
	wire [EVENTS-1:0] clearBits = statusWe ? wdata : '0;

	// ****************************************
	// Sticky status, write one to clear, set wins
	// ****************************************
	assign statusNext = clearAll ? '0 : ((statusReg & ~clearBits) | events);
	assign maskNext = clearAll ? INT_MASK_RST[EVENTS-1:0] : (maskWe ? wdata : maskReg);
	assign irqActive = intEnable && |(statusReg & maskReg);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			statusReg <= '0;
			maskReg <= INT_MASK_RST[EVENTS-1:0];
		end else begin
			statusReg <= statusNext;
			maskReg <= maskNext;
		end
	end
endmodule

//--- lineif_ctrl.sv
// Contract
// - Hardware Mode loop pins far,near: 00 normal, 01 analog local, 10 remote, 11 digital.
// - In host mode both loopback pins are ignored; board ties them low.
// - Serial input bits are captured on rising shift clock edges.
// - Serial output changes only on falling shift clock edges during reads.
// - A read shifts out the addressed command register, one bit at a time.
// - After a transfer the serial output floats until the next read drives it.
// - Register reset low returns all command registers and configuration to defaults.
// - In host mode a pending interrupt drives the interrupt pin low.
// - Interrupt enable bit at zero keeps the interrupt pin from asserting.
// - In Hardware Mode the serial pins become clock invert, receiver and mute controls; the code takes mute from the interrupt pin.
// - Mute enabled with loss of signal forces both recovered data outputs low.
// - Analog local or remote loopback overrides an all-ones transmit request.
//
// Added by the designer: the placing of the registers and the strobed register port.
module lineif_ctrl (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic hostModePin,
	input wire logic regResetPin_n,
	input wire logic selectPin,
	input wire logic shiftClockPin,
	input wire logic serial_write_in,
	input wire logic serialReadIn,
	output logic serial_read_out,
	output logic serialReadOe_n,
	input wire logic irqPinIn,
	output logic irq_out_n,
	output logic irqOe_n,
	input wire logic near_end_loop_sel,
	input wire logic far_end_loop_sel,
	input wire logic all_ones_transmit,
	input wire logic losIn,
	input wire logic recvPosIn,
	input wire logic recvNegIn,
	output logic recv_pos_data,
	output logic recv_neg_data,
	output logic loopNormal,
	output logic loopAnalogLocal,
	output logic loopRemote,
	output logic loopDigital,
	output logic allOnesOut,
	output logic recv_clock_invert,
	output logic xmit_clock_invert,
	output logic receiver_on,
	output logic receive_monitor_mode,
	output logic mute_on_signal_loss
);
	import lineif_pkg::*;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [9:0] pinsS;
	pin_sync #(.WIDTH(10)) u_sync (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.pinIn({hostModePin, regResetPin_n, selectPin, shiftClockPin, serial_write_in, serialReadIn, irqPinIn,
			near_end_loop_sel, far_end_loop_sel, all_ones_transmit}),
		.pinOut(pinsS)
	);
	wire hostS = pinsS[9];
	wire regResetS_n = pinsS[8];
	wire selS = pinsS[7];
	wire sclkS = pinsS[6];
	wire dinS = pinsS[5];
	wire readPinS = pinsS[4];
	wire irqInS = pinsS[3];
	wire nearS = pinsS[2];
	wire farS = pinsS[1];
	wire allOnesS = pinsS[0];

	// ****************************************
	// Shift clock edges
	// ****************************************
	logic sclkD;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sclkD <= 1'b0;
		end else begin
			sclkD <= sclkS;
		end
	end
	wire sclkRise = sclkS && !sclkD;
	wire sclkFall = !sclkS && sclkD;

	// ****************************************
	// Serial port state
	// ****************************************
	port_state_type state;
	port_state_type stateNext;
	logic [FRAME_BITS-1:0] shiftReg;
	logic [4:0] bitCnt;
	logic [ADDR_BITS-1:0] addrReg;
	logic [DATA_BITS-1:0] readShift;
	logic [DATA_BITS-1:0] readShiftNext;
	logic outBit;
	logic outDrive;
	logic outDriveNext;
	logic [7:0] ctrlReg;
	logic [7:0] clkReg;
	logic [EVENT_COUNT-1:0] statusReg;
	logic [EVENT_COUNT-1:0] maskReg;
	logic irqActive;

	wire active = hostS && !selS;
	wire [FRAME_BITS-1:0] capNext = {shiftReg[FRAME_BITS-2:0], dinS};
	wire headDone = sclkRise && (state == SP_HEAD) && (bitCnt == HEAD_LAST);
	wire frameDone = sclkRise && (bitCnt == FRAME_LAST);
	wire rwFlag = capNext[ADDR_BITS];
	wire [ADDR_BITS-1:0] headAddr = capNext[ADDR_BITS-1:0];
	wire writeStb = frameDone && (state == SP_WDATA) && active;
	wire [DATA_BITS-1:0] writeData = capNext[DATA_BITS-1:0];

	// ****************************************
	// Register read selection
	// ****************************************
	wire [7:0] statusWord = {{(8 - EVENT_COUNT){1'b0}}, statusReg};
	wire [7:0] maskWord = {{(8 - EVENT_COUNT){1'b0}}, maskReg};
	wire [7:0] alarmWord = {7'h00, losIn};
	wire [7:0] readWord = (headAddr == CHAN_CTRL_ADDR) ? ctrlReg :
		(headAddr == INT_MASK_ADDR) ? maskWord :
		(headAddr == INT_STAT_ADDR) ? statusWord :
		(headAddr == ALARM_STAT_ADDR) ? alarmWord :
		(headAddr == CLK_CTRL_ADDR) ? clkReg : 8'h00;

	always_comb begin
		stateNext = state;
		readShiftNext = readShift;
		outDriveNext = outDrive;
		if (!active) begin
			stateNext = SP_IDLE;
			outDriveNext = 1'b0;
		end else begin
			case (state)
				SP_IDLE: begin
					stateNext = SP_HEAD;
				end
				SP_HEAD: begin
					if (headDone && rwFlag == RW_READ) begin
						stateNext = SP_RDATA;
						readShiftNext = readWord;
					end else if (headDone) begin
						stateNext = SP_WDATA;
					end
				end
				SP_WDATA: begin
					if (frameDone) begin
						stateNext = SP_DONE;
					end
				end
				SP_RDATA: begin
					if (frameDone) begin
						stateNext = SP_DONE;
						outDriveNext = 1'b0;
					end else if (sclkFall) begin
						outDriveNext = 1'b1;
						readShiftNext = {readShift[DATA_BITS-2:0], 1'b0};
					end
				end
				SP_DONE: begin
					stateNext = SP_DONE;
				end
				default: begin
					stateNext = SP_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state <= SP_IDLE;
			readShift <= 8'h00;
			outDrive <= 1'b0;
		end else begin
			state <= stateNext;
			readShift <= readShiftNext;
			outDrive <= outDriveNext;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			shiftReg <= '0;
			bitCnt <= 5'h00;
			addrReg <= '0;
		end else if (!active || state == SP_IDLE) begin
			bitCnt <= 5'h00;
		end else if (sclkRise && state != SP_DONE) begin
			shiftReg <= capNext;
			bitCnt <= bitCnt + 5'h01;
			if (headDone) begin
				addrReg <= headAddr;
			end
		end
	end

	// Output bit changes only on a falling edge
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			outBit <= 1'b0;
		end else if (state == SP_RDATA && sclkFall && !frameDone) begin
			outBit <= readShift[DATA_BITS-1];
		end
	end

	// ****************************************
	// Command registers
	// ****************************************
	wire wrCtrl = writeStb && addrReg == CHAN_CTRL_ADDR;
	wire wrMask = writeStb && addrReg == INT_MASK_ADDR;
	wire wrStat = writeStb && addrReg == INT_STAT_ADDR;
	wire wrClk = writeStb && addrReg == CLK_CTRL_ADDR;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrlReg <= CHAN_CTRL_RST;
			clkReg <= CLK_CTRL_RST;
		end else if (!regResetS_n) begin
			ctrlReg <= CHAN_CTRL_RST;
			clkReg <= CLK_CTRL_RST;
		end else begin
			if (wrCtrl) begin
				ctrlReg <= writeData;
			end
			if (wrClk) begin
				clkReg <= writeData;
			end
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	logic losD;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			losD <= 1'b0;
		end else begin
			losD <= losIn;
		end
	end
	wire [EVENT_COUNT-1:0] events = {losD && !losIn, losIn && !losD};

	int_ctrl #(.EVENTS(EVENT_COUNT)) u_int (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.clearAll(!regResetS_n),
		.events(events),
		.maskWe(wrMask),
		.statusWe(wrStat),
		.wdata(writeData[EVENT_COUNT-1:0]),
		.intEnable(ctrlReg[CTRL_INT_EN]),
		.statusReg(statusReg),
		.maskReg(maskReg),
		.irqActive(irqActive)
	);

	// ****************************************
	// Configuration and loopback outputs
	// ****************************************
	wire [1:0] loopSel = hostS ? {ctrlReg[CTRL_FAR_LOOP], ctrlReg[CTRL_NEAR_LOOP]} : {farS, nearS};
	wire muteSel = hostS ? ctrlReg[CTRL_MUTE] : irqInS;
	wire allOnesSel = hostS ? ctrlReg[CTRL_ALL_ONES] : allOnesS;
	wire loopOverride = (loopSel == 2'h1) || (loopSel == 2'h2);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			loopNormal <= 1'b1;
			loopAnalogLocal <= 1'b0;
			loopRemote <= 1'b0;
			loopDigital <= 1'b0;
			allOnesOut <= 1'b0;
			mute_on_signal_loss <= 1'b0;
		end else begin
			loopNormal <= loopSel == 2'h0;
			loopAnalogLocal <= loopSel == 2'h1;
			loopRemote <= loopSel == 2'h2;
			loopDigital <= loopSel == 2'h3;
			allOnesOut <= allOnesSel && !loopOverride;
			mute_on_signal_loss <= muteSel;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			recv_clock_invert <= 1'b0;
			xmit_clock_invert <= 1'b0;
			receiver_on <= 1'b0;
			receive_monitor_mode <= 1'b0;
		end else if (hostS) begin
			recv_clock_invert <= clkReg[CLK_RX_INV];
			xmit_clock_invert <= clkReg[CLK_TX_INV];
			receiver_on <= ctrlReg[CTRL_RX_ON];
			receive_monitor_mode <= ctrlReg[CTRL_RX_MON];
		end else begin
			recv_clock_invert <= selS;
			xmit_clock_invert <= sclkS;
			receiver_on <= dinS;
			receive_monitor_mode <= readPinS;
		end
	end

	// Muted recovered data
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			recv_pos_data <= 1'b0;
			recv_neg_data <= 1'b0;
		end else begin
			recv_pos_data <= recvPosIn && !(muteSel && losIn);
			recv_neg_data <= recvNegIn && !(muteSel && losIn);
		end
	end

	// ****************************************
	// Pin drivers
	// ****************************************
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			irq_out_n <= 1'b1;
		end else begin
			irq_out_n <= !(hostS && irqActive);
		end
	end
	assign irqOe_n = !hostS;
	assign serial_read_out = outBit;
	assign serialReadOe_n = !(outDrive && active);

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	a_loop_hw_decode: assert property (!hostS |=> loopRemote == ($past(farS) && !$past(nearS))
		&& loopAnalogLocal == (!$past(farS) && $past(nearS)))
		else $error("hardware loop decode wrong");
	a_loop_host_pins: assert property (hostS && $stable(ctrlReg) && $stable(hostS)
		|=> loopDigital == ($past(ctrlReg[CTRL_FAR_LOOP]) && $past(ctrlReg[CTRL_NEAR_LOOP])))
		else $error("host loop not from register");
	a_capture_rise: assert property (active && sclkRise && state == SP_HEAD
		|=> bitCnt == $past(bitCnt) + 5'h01 && shiftReg[0] == $past(dinS))
		else $error("bit not captured on rise");
	a_read_fall_only: assert property ($changed(outBit) |-> $past(sclkFall))
		else $error("serial output changed off a falling edge");
	a_read_load: assert property (headDone && active && rwFlag == RW_READ
		|=> state == SP_RDATA && readShift == $past(readWord))
		else $error("read word not loaded");
	a_read_release: assert property (selS |=> serialReadOe_n)
		else $error("serial output driven outside transfer");
	a_reg_reset: assert property (!regResetS_n |=> ctrlReg == CHAN_CTRL_RST && statusReg == '0)
		else $error("register reset ignored");
	a_irq_assert: assert property (hostS && irqActive |=> !irq_out_n && !irqOe_n)
		else $error("interrupt not driven low");
	a_irq_disabled: assert property (!ctrlReg[CTRL_INT_EN] |=> irq_out_n)
		else $error("interrupt asserted while disabled");
	a_mute_los: assert property (muteSel && losIn |=> !recv_pos_data && !recv_neg_data)
		else $error("recovered data not muted");
	a_loop_priority: assert property (loopOverride |=> !allOnesOut)
		else $error("all ones beat loopback");
	a_irq_hold: assert property (hostS && !irq_out_n && $stable(hostS) && !wrStat && !$past(wrStat)
		&& regResetS_n && $stable(ctrlReg) && $stable(maskReg) |=> !irq_out_n)
		else $error("interrupt dropped without clear");
	a_write_frame: assert property (writeStb && addrReg == CLK_CTRL_ADDR && regResetS_n
		|=> clkReg == $past(writeData))
		else $error("write frame not applied");

	c_read_frame: cover property (state == SP_RDATA ##[1:300] state == SP_DONE);
	c_write_frame: cover property (writeStb && addrReg == CHAN_CTRL_ADDR);
	c_irq_cycle: cover property (!irq_out_n ##[1:300] irq_out_n);
	c_hw_mute: cover property (!hostS && muteSel && losIn);
endmodule

//--- lineif_host_model.sv
module lineif_host_model (
	input wire logic sys_clk,
	input wire logic readWire,
	output logic selectN,
	output logic shiftClk,
	output logic dataBit
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		selectN = 1'b1;
		shiftClk = 1'b0;
		dataBit = 1'b0;
	end

	// ****************************************
	// One serial frame, cut short when nbits < 16
	// ****************************************
	task automatic xfer(input logic rw, input logic [6:0] addr, input logic [7:0] wd, input int nbits,
		output logic [7:0] rd);
		logic [15:0] frame;
		frame = {rw, addr, wd};
		rd = 8'h00;
		@(posedge sys_clk);
		selectN <= 1'b0;
		repeat (4) @(posedge sys_clk);
		for (int i = 0; i < nbits; i++) begin
			dataBit <= frame[15 - i];
			repeat (4) @(posedge sys_clk);
			shiftClk <= 1'b1;
			if (i >= 8) rd = {rd[6:0], readWire};
			repeat (4) @(posedge sys_clk);
			shiftClk <= 1'b0;
		end
		repeat (4) @(posedge sys_clk);
		selectN <= 1'b1;
		dataBit <= 1'b0;
		repeat (8) @(posedge sys_clk);
	endtask
endmodule

//--- lineif_host_serial_and_loopback_test.sv
module lineif_host_serial_and_loopback_test;
	import lineif_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************
	// Pins and pin levels
	// ****************************************
	logic sys_clk, rstn, hostModePin, regResetPin_n, near_end_loop_sel, far_end_loop_sel, all_ones_transmit;
	logic losIn, recvPosIn, recvNegIn, hwSel, hwSclk, hwDin, hwMon, hwMute, prevOut;
	wire selectPin, shiftClockPin, serial_write_in, serialReadIn, irqPinIn, mSel, mSclk, mDin;
	wire serial_read_out, serialReadOe_n, irq_out_n, irqOe_n, recv_pos_data, recv_neg_data;
	wire loopNormal, loopAnalogLocal, loopRemote, loopDigital, allOnesOut;
	wire recv_clock_invert, xmit_clock_invert, receiver_on, receive_monitor_mode, mute_on_signal_loss;
	int errCount, nChecks;
	logic [7:0] rd;

	assign selectPin = hostModePin ? mSel : hwSel;
	assign shiftClockPin = hostModePin ? mSclk : hwSclk;
	assign serial_write_in = hostModePin ? mDin : hwDin;
	assign serialReadIn = !serialReadOe_n ? serial_read_out : (hostModePin ? !serial_read_out : hwMon);
	assign irqPinIn = !irqOe_n ? irq_out_n : hwMute;

	lineif_ctrl u_lineif_ctrl (.sys_clk, .rstn, .hostModePin, .regResetPin_n, .selectPin, .shiftClockPin,
		.serial_write_in, .serialReadIn, .serial_read_out, .serialReadOe_n, .irqPinIn, .irq_out_n, .irqOe_n,
		.near_end_loop_sel, .far_end_loop_sel, .all_ones_transmit, .losIn, .recvPosIn, .recvNegIn,
		.recv_pos_data, .recv_neg_data, .loopNormal, .loopAnalogLocal, .loopRemote, .loopDigital, .allOnesOut,
		.recv_clock_invert, .xmit_clock_invert, .receiver_on, .receive_monitor_mode, .mute_on_signal_loss);

	lineif_host_model u_lineif_host_model (.sys_clk, .readWire(serialReadIn), .selectN(mSel), .shiftClk(mSclk),
		.dataBit(mDin));

	always #50 sys_clk = !sys_clk;

	always @(posedge sys_clk) begin
		prevOut <= serial_read_out;
		if (!serialReadOe_n && mSclk) begin
			check({11'h000, serial_read_out}, {11'h000, prevOut});
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input logic [11:0] seen, input logic [11:0] want);
		nChecks++;
		if (seen !== want) begin
			errCount++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic wr(input logic [6:0] addr, input logic [7:0] data);
		u_lineif_host_model.xfer(1'b0, addr, data, 16, rd);
	endtask

	task automatic rd_check(input logic [6:0] addr, input logic [7:0] want);
		u_lineif_host_model.xfer(RW_READ, addr, 8'h00, 16, rd);
		check({4'h0, rd}, {4'h0, want});
	endtask

	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", nChecks, errCount);
		if (errCount == 0 && nChecks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ****************************************
	// Hardware Mode rows: pins in, outputs expected
	// ****************************************
	typedef struct packed {
		logic [10:0] pins;
		logic [11:0] want;
	} row_type;
	row_type rows [4] = '{'{11'h1AF, 12'h8D4}, '{11'h357, 12'h42B}, '{11'h5FA, 12'h27E}, '{11'h701, 12'h181}};

	initial begin
		repeat (20000) @(posedge sys_clk);
		errCount++;
		$display("Error at %0t: watchdog expired", $time);
		end_sim();
	end

	initial begin
		{sys_clk, rstn, hostModePin, near_end_loop_sel, far_end_loop_sel, all_ones_transmit} = 6'h00;
		{losIn, recvPosIn, recvNegIn, hwSel, hwSclk, hwDin, hwMon, hwMute, prevOut} = 9'h000;
		regResetPin_n = 1'b1;
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		foreach (rows[i]) begin
			{far_end_loop_sel, near_end_loop_sel, all_ones_transmit, hwSel, hwSclk, hwDin, hwMon, hwMute, losIn,
				recvPosIn, recvNegIn} <= rows[i].pins;
			repeat (5) @(posedge sys_clk);
			check({loopNormal, loopAnalogLocal, loopRemote, loopDigital, allOnesOut, recv_clock_invert,
				xmit_clock_invert, receiver_on, receive_monitor_mode, mute_on_signal_loss, recv_pos_data,
				recv_neg_data}, rows[i].want);
		end
		$display("Test done: hardware mode rows");
		{hostModePin, far_end_loop_sel, near_end_loop_sel, all_ones_transmit, losIn} <= 5'h1E;
		repeat (6) @(posedge sys_clk);
		check({9'h000, loopNormal, loopDigital, allOnesOut}, 12'h004);
		rd_check(CHAN_CTRL_ADDR, CHAN_CTRL_RST);
		rd_check(INT_MASK_ADDR, 8'h00);
		rd_check(CLK_CTRL_ADDR, CLK_CTRL_RST);
		rd_check(7'h7F, 8'h00);
		check({11'h000, serialReadOe_n}, 12'h001);
		$display("Test done: reset values");
		u_lineif_host_model.xfer(1'b0, CLK_CTRL_ADDR, 8'h03, 10, rd);
		rd_check(CLK_CTRL_ADDR, 8'h00);
		wr(CLK_CTRL_ADDR, 8'h02);
		check({10'h000, recv_clock_invert, xmit_clock_invert}, 12'h001);
		wr(CHAN_CTRL_ADDR, 8'h59);
		check({9'h000, loopDigital, receive_monitor_mode, receiver_on}, 12'h006);
		rd_check(CHAN_CTRL_ADDR, 8'h59);
		$display("Test done: abort and writes");
		rd_check(INT_STAT_ADDR, 8'h03);
		wr(INT_STAT_ADDR, 8'h03);
		wr(INT_MASK_ADDR, 8'h01);
		check({11'h000, irq_out_n}, 12'h001);
		losIn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		check({10'h000, irq_out_n, irqOe_n}, 12'h000);
		rd_check(INT_STAT_ADDR, 8'h01);
		rd_check(ALARM_STAT_ADDR, 8'h01);
		wr(INT_STAT_ADDR, 8'h01);
		check({11'h000, irq_out_n}, 12'h001);
		wr(CHAN_CTRL_ADDR, 8'h20);
		wr(INT_MASK_ADDR, 8'h03);
		losIn <= 1'b0;
		repeat (4) @(posedge sys_clk);
		check({11'h000, irq_out_n}, 12'h001);
		rd_check(INT_STAT_ADDR, 8'h02);
		wr(CHAN_CTRL_ADDR, 8'h21);
		check({11'h000, irq_out_n}, 12'h000);
		$display("Test done: interrupt");
		regResetPin_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		regResetPin_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		check({11'h000, irq_out_n}, 12'h001);
		rd_check(CHAN_CTRL_ADDR, CHAN_CTRL_RST);
		rd_check(INT_MASK_ADDR, 8'h00);
		rd_check(INT_STAT_ADDR, 8'h00);
		$display("Test done: register reset");
		end_sim();
	end
endmodule
